// ### logic/phase_step_map.svh
// offsets, fields and timing counts for the phase step controller
`ifndef PHASE_STEP_MAP_SVH
`define PHASE_STEP_MAP_SVH
`define SEL_ALL_OUTPUTS 3'h0
`define SEL_FEEDBACK 3'h1
`define SEL_OUT_FIRST 3'h2
`define SEL_OUT_LAST 3'h6
`define TAPS_PER_PERIOD 8
`define SHIFT_CYCLES_DEFAULT 3
`define DONE_RESET 1'h1
`endif

// ### logic/phase_step_pkg.sv
// types for the phase step controller
package phase_step_pkg;
   typedef enum logic [1:0] {
      st_idle_type_e, st_wait_type_e, st_shift_type_e, st_release_type_e
   } step_state_type;
   typedef logic [2:0] tap_type;
endpackage

// ### logic/pll_dynamic_phase_step_ctrl.sv
// phase step handshake controller, sampling the reconfiguration clock
//
// How it works
// - Control inputs are sampled at detected scan clock edges; only the release of the step request is polled every mclk cycle.
// - The step request is taken at a falling edge of the scan clock.
// - At the second rise after the request, direction and target are taken.
// - At that rise the completion flag falls and stays low until the end.
// - The completion flag low time is not fixed in scan clock cycles.
// - Target 0 is all outputs, 1 feedback, 2 to 6 outputs zero to four.
// - Direction 1 moves the phase later and 0 moves it earlier.
// - Each step moves the selected tap by one eighth of a period.
// - Output clocks keep running during a step.
`timescale 1ns/10ps
`include "phase_step_map.svh"
module pll_dynamic_phase_step_ctrl #(
   parameter int NUM_OUTPUTS = 5,
   parameter int SHIFT_CYCLES = `SHIFT_CYCLES_DEFAULT
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic scan_clk,
   input wire logic phase_step,
   input wire logic phase_up,
   input wire logic [2:0] counter_select,
   output logic phase_done,
   output logic [2:0] feedback_tap,
   output logic [14:0] output_taps,
   output logic clocks_running
);
   // tap loop is fixed at five outputs; shift counter is eight bits
   if (NUM_OUTPUTS != 5 || SHIFT_CYCLES < 1 ||
       SHIFT_CYCLES > 255) begin : bad_params
      $error("unsupported parameters");
   end

   // two-flop synchronisers; first stage read only by the second
   logic [5:0] s1_q, s2_q, s3_q;
   always_ff @(posedge mclk) begin
      if (reset) begin
         s1_q <= 6'h00;
         s2_q <= 6'h00;
         s3_q <= 6'h00;
      end else begin
         s1_q <= {scan_clk, phase_step, phase_up, counter_select};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   logic clk_rise, clk_fall;
   assign clk_rise = s2_q[5] && !s3_q[5];
   assign clk_fall = !s2_q[5] && s3_q[5];

   phase_step_pkg::step_state_type state_q, state_d;
   logic [1:0] rise_cnt_q, rise_cnt_d;
   logic [7:0] shift_cnt_q, shift_cnt_d;
   logic done_q, done_d;
   logic up_q, up_d;
   logic [2:0] sel_q, sel_d;
   logic [2:0] fb_q, fb_d;
   logic [14:0] out_q, out_d;

   always_comb begin
      state_d = state_q;
      rise_cnt_d = rise_cnt_q;
      shift_cnt_d = shift_cnt_q;
      done_d = done_q;
      up_d = up_q;
      sel_d = sel_q;
      fb_d = fb_q;
      out_d = out_q;
      unique case (state_q)
         phase_step_pkg::st_idle_type_e: begin
            done_d = 1'h1;
            if (clk_fall && s2_q[4]) begin
               state_d = phase_step_pkg::st_wait_type_e;
               rise_cnt_d = 2'h0;
            end
         end
         phase_step_pkg::st_wait_type_e: begin
            if (clk_rise) begin
               rise_cnt_d = rise_cnt_q + 2'h1;
               if (rise_cnt_q == 2'h1) begin
                  up_d = s2_q[3];
                  sel_d = s2_q[2:0];
                  done_d = 1'h0;
                  shift_cnt_d = 8'(SHIFT_CYCLES);
                  state_d = phase_step_pkg::st_shift_type_e;
               end
            end
         end
         phase_step_pkg::st_shift_type_e: begin
            // low time follows mclk, not scan clock: it is not fixed
            if (shift_cnt_q == 8'h01) begin
               // one tap is one eighth period; taps wrap mod 8
               if (sel_q == `SEL_FEEDBACK) begin
                  fb_d = up_q ? fb_q + 3'h1 : fb_q - 3'h1;
               end
               for (int i = 0; i < 5; i++) begin
                  if (sel_q == `SEL_ALL_OUTPUTS ||
                      sel_q == 3'(i + 2)) begin
                     out_d[i*3 +: 3] = up_q ? out_q[i*3 +: 3] + 3'h1
                                           : out_q[i*3 +: 3] - 3'h1;
                  end
               end
               done_d = 1'h1;
               state_d = phase_step_pkg::st_release_type_e;
            end else begin
               shift_cnt_d = shift_cnt_q - 8'h01;
            end
         end
         phase_step_pkg::st_release_type_e: begin
            // a request still held after done would retrigger; wait low
            if (!s2_q[4]) begin
               state_d = phase_step_pkg::st_idle_type_e;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= phase_step_pkg::st_idle_type_e;
         rise_cnt_q <= 2'h0;
         shift_cnt_q <= 8'h00;
         done_q <= `DONE_RESET;
         up_q <= 1'h0;
         sel_q <= 3'h0;
         fb_q <= 3'h0;
         out_q <= 15'h0000;
      end else begin
         state_q <= state_d;
         rise_cnt_q <= rise_cnt_d;
         shift_cnt_q <= shift_cnt_d;
         done_q <= done_d;
         up_q <= up_d;
         sel_q <= sel_d;
         fb_q <= fb_d;
         out_q <= out_d;
      end
   end

   logic run_q;
   always_ff @(posedge mclk) begin
      if (reset) begin
         run_q <= 1'h0;
      end else begin
         run_q <= 1'h1;
      end
   end

   assign phase_done = done_q;
   assign feedback_tap = fb_q;
   assign output_taps = out_q;
   assign clocks_running = run_q;

   chk_done_idle: assert property (
      @(posedge mclk) disable iff (reset)
      state_q == phase_step_pkg::st_idle_type_e |-> phase_done)
      else $error("done low while idle");
   chk_done_low_shift: assert property (
      @(posedge mclk) disable iff (reset)
      state_q == phase_step_pkg::st_shift_type_e |-> !phase_done)
      else $error("done high during shift");
   chk_fall_at_rise: assert property (
      @(posedge mclk) disable iff (reset)
      $fell(phase_done) |-> $past(clk_rise))
      else $error("done fell off a rising edge");
   chk_shift_bounded: assert property (
      @(posedge mclk) disable iff (reset)
      $fell(phase_done) |-> ##[1:256] phase_done)
      else $error("shift never ended");
   chk_start_on_fall: assert property (
      @(posedge mclk) disable iff (reset)
      state_q == phase_step_pkg::st_idle_type_e &&
      state_d == phase_step_pkg::st_wait_type_e |-> clk_fall && s2_q[4])
      else $error("request taken off a falling edge");
   chk_fb_step: assert property (
      @(posedge mclk) disable iff (reset)
      $rose(phase_done) && sel_q == `SEL_FEEDBACK && up_q
      |-> fb_q == $past(fb_q) + 3'h1)
      else $error("feedback tap not stepped up");
   chk_fb_hold: assert property (
      @(posedge mclk) disable iff (reset)
      sel_q != `SEL_FEEDBACK |=> $stable(fb_q))
      else $error("feedback tap moved when not selected");
   chk_clocks_run: assert property (
      @(posedge mclk) disable iff (reset)
      !phase_done |-> clocks_running)
      else $error("clocks stopped during step");
   // a capture on the first rise would shorten the setup window
   chk_second_rise: assert property (
      @(posedge mclk) disable iff (reset)
      $fell(phase_done) |-> $past(state_q) ==
      phase_step_pkg::st_wait_type_e && $past(rise_cnt_q) == 2'h1)
      else $error("capture not on second rise");
   chk_rise_release: assert property (
      @(posedge mclk) disable iff (reset)
      $rose(phase_done) |-> state_q == phase_step_pkg::st_release_type_e)
      else $error("done rose outside shift end");
   chk_wait_ready: assert property (
      @(posedge mclk) disable iff (reset)
      state_q == phase_step_pkg::st_wait_type_e |-> phase_done)
      else $error("done low before capture");
   // taps must only move together with the done edge
   chk_taps_on_done: assert property (
      @(posedge mclk) disable iff (reset)
      !$rose(phase_done) |-> $stable(output_taps))
      else $error("output taps moved outside a step end");
   chk_out_hold: assert property (
      @(posedge mclk) disable iff (reset)
      sel_q == `SEL_FEEDBACK |=> $stable(output_taps))
      else $error("output taps moved on feedback step");
   chk_all_down: assert property (
      @(posedge mclk) disable iff (reset)
      $rose(phase_done) && sel_q == `SEL_ALL_OUTPUTS && !up_q
      |-> output_taps[14:12] == $past(output_taps[14:12]) - 3'h1)
      else $error("last output tap not stepped down");
   cov_step_up: cover property (
      @(posedge mclk) disable iff (reset)
      $rose(phase_done) && up_q);
   cov_step_down: cover property (
      @(posedge mclk) disable iff (reset)
      $rose(phase_done) && !up_q);
   cov_all_outputs: cover property (
      @(posedge mclk) disable iff (reset)
      $rose(phase_done) && sel_q == `SEL_ALL_OUTPUTS);
   cov_feedback: cover property (
      @(posedge mclk) disable iff (reset)
      $rose(phase_done) && sel_q == `SEL_FEEDBACK);
   cov_single_output: cover property (
      @(posedge mclk) disable iff (reset)
      $rose(phase_done) && sel_q >= `SEL_OUT_FIRST &&
      sel_q <= `SEL_OUT_LAST);
endmodule

// ### tb/step_driver.sv
// core-side model that issues phase steps to the controller
`timescale 1ns/10ps
module step_driver (
   input wire logic mclk,
   input wire logic scan_clk,
   input wire logic phase_done,
   output logic phase_step,
   output logic phase_up,
   output logic [2:0] counter_select
);
   logic seen_low = 1'h0;
   logic held_high = 1'h0;
   initial begin
      phase_step = 1'h0;
      phase_up = 1'h0;
      counter_select = 3'h7;
   end
   // change just after a scan rise, clear of both sample edges
   task automatic sync_edge();
      @(posedge scan_clk);
      @(negedge mclk);
   endtask
   task automatic do_step(input logic up, input logic [2:0] sel);
      int n;
      sync_edge();
      phase_up = up;
      counter_select = sel;
      phase_step = 1'h1;
      sync_edge();
      // before the second rise the flag must still be high
      repeat (4) @(negedge mclk);
      held_high = phase_done;
      sync_edge();
      // second rise has passed; a late capture would see the flip
      phase_up = ~up;
      counter_select = ~sel;
      // low time is not fixed, so poll rather than count
      for (n = 0; n < 400; n++) begin
         if (!phase_done) break;
         @(negedge mclk);
      end
      seen_low = !phase_done;
      sync_edge();
      phase_step = 1'h0;
      for (n = 0; n < 400; n++) begin
         if (phase_done) break;
         @(negedge mclk);
      end
      sync_edge();
   endtask
endmodule

// ### tb/test_pll_dynamic_phase_step_ctrl.sv
// self-checking bench for the phase step controller
`timescale 1ns/10ps
module test_pll_dynamic_phase_step_ctrl;
   logic mclk = 1'h0;
   logic reset = 1'h1;
   logic scan_clk = 1'h0;
   logic phase_step, phase_up, phase_done, clocks_running;
   logic [2:0] counter_select, feedback_tap, exp_fb;
   logic [14:0] output_taps, exp_out;
   int n_fail = 0;
   int check_count = 0;
   initial begin
      forever #50 mclk = ~mclk;
   end
   // free-running scan clock, phase unrelated to mclk
   initial begin
      #137;
      forever #400 scan_clk = ~scan_clk;
   end
   pll_dynamic_phase_step_ctrl i_dut (.mclk(mclk), .reset(reset),
      .scan_clk(scan_clk), .phase_step(phase_step), .phase_up(phase_up),
      .counter_select(counter_select), .phase_done(phase_done),
      .feedback_tap(feedback_tap), .output_taps(output_taps),
      .clocks_running(clocks_running));
   step_driver i_drv (.mclk(mclk), .scan_clk(scan_clk),
      .phase_done(phase_done), .phase_step(phase_step),
      .phase_up(phase_up), .counter_select(counter_select));
   task automatic chk(input logic [14:0] got, input logic [14:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   function automatic logic [2:0] bump(input logic [2:0] v, input logic up);
      return v + (up ? 3'h1 : 3'h7);
   endfunction
   task automatic step(input logic up, input logic [2:0] sel);
      i_drv.do_step(up, sel);
      for (int i = 0; i < 5; i++) begin
         if (sel == 3'h0 || sel == i + 2) begin
            exp_out[3*i +: 3] = bump(exp_out[3*i +: 3], up);
         end
      end
      if (sel == 3'h1) exp_fb = bump(exp_fb, up);
      chk({14'h0, i_drv.seen_low}, 15'h1);
      chk({14'h0, i_drv.held_high}, 15'h1);
      chk(output_taps, exp_out);
      chk({12'h0, feedback_tap}, {12'h0, exp_fb});
      chk({13'h0, phase_done, clocks_running}, 15'h3);
   endtask
   initial begin
      exp_out = 15'h0;
      exp_fb = 3'h0;
      repeat (20) @(negedge mclk);
      reset = 1'h0;
      @(negedge mclk);
      chk({13'h0, phase_done, clocks_running}, 15'h3);
      chk(output_taps, 15'h0);
      // downward first so every tap wraps below zero
      for (int s = 0; s < 8; s++) step(1'h0, s[2:0]);
      for (int s = 7; s >= 0; s--) step(1'h1, s[2:0]);
      step(1'h1, 3'h4);
      step(1'h1, 3'h4);
      // a mid-run reset clears the taps and leaves the flag high
      reset = 1'h1;
      repeat (3) @(negedge mclk);
      chk({13'h0, phase_done, clocks_running}, 15'h2);
      reset = 1'h0;
      exp_out = 15'h0;
      exp_fb = 3'h0;
      @(negedge mclk);
      chk(output_taps, exp_out);
      chk({12'h0, feedback_tap}, 15'h0);
      step(1'h1, 3'h1);
      end_sim();
   end
   initial begin
      #400000;
      n_fail++;
      $display("ERROR at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule
